// ---- core/arith_iterative_unit.sv ----
`timescale 1ns/1ps
module arith_iterative_unit
  import aiu_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // issue from integer_pipe
  input wire logic issue_valid_in,
  input wire aiu_issue_t issue_in,
  output logic ready_out,
  // general register result
  output aiu_gpr_t gpr_out,
  // result pair
  output logic [DATA_W-1:0] upper_result_out,
  output logic [DATA_W-1:0] bottom_result_out
);

  if (DATA_W != AIU_W) begin : g_width_check
    $error("arith_iterative_unit serves only a 32-bit datapath");
  end

  aiu_state_t state_ff, nxt_state;
  logic ready_ff, nxt_ready;
  logic [63:0] pair_ff, nxt_pair;
  aiu_op_t p2_op_ff, nxt_p2_op;
  logic p2_sgn_ff, nxt_p2_sgn;
  logic [31:0] p2_a_ff, nxt_p2_a;
  logic [15:0] p2_bhi_ff, nxt_p2_bhi;
  logic [63:0] p2_lo_ff, nxt_p2_lo;
  aiu_gpr_t stage_ff, nxt_stage;
  aiu_gpr_t gpr_ff, nxt_gpr;
  logic [5:0] div_cnt_ff, nxt_div_cnt;
  logic [5:0] div_left_ff, nxt_div_left;
  logic [31:0] div_rem_ff, nxt_div_rem;
  logic [31:0] div_quo_ff, nxt_div_quo;
  logic [31:0] div_d_ff, nxt_div_d;
  logic div_qneg_ff, nxt_div_qneg;
  logic div_rneg_ff, nxt_div_rneg;

  // shared booth array inputs and result
  logic signed [32:0] mul_a;
  logic signed [16:0] mul_y;
  logic [18:0] mul_ybits;
  logic signed [AIU_PP_W-1:0] pp [AIU_BOOTH_DIGITS];
  logic signed [AIU_PP_W-1:0] mul_sum;

  function automatic logic signed [AIU_PP_W-1:0] booth_pp(
    input logic [2:0] dig,
    input logic signed [32:0] a,
    input int pos
  );
    logic signed [AIU_PP_W-1:0] ax;
    logic signed [AIU_PP_W-1:0] v;
    ax = AIU_PP_W'(a);
    case (dig)
      3'h1, 3'h2: v = ax;
      3'h3: v = ax <<< 1;
      3'h4: v = -(ax <<< 1);
      3'h5, 3'h6: v = -ax;
      default: v = '0;
    endcase
    return v <<< (2 * pos);
  endfunction

  // one restoring step: returns {remainder, quotient}
  function automatic logic [63:0] div_step(
    input logic [31:0] rem,
    input logic [31:0] quo,
    input logic [31:0] d
  );
    logic [33:0] diff;
    logic [32:0] sh;
    sh = {rem, quo[31]};
    diff = {1'b0, sh} - {2'h0, d};
    if (!diff[33]) begin
      return {diff[31:0], quo[30:0], 1'b1};
    end
    return {sh[31:0], quo[30:0], 1'b0};
  endfunction

  // radix-4 recoding of the 16-bit slice plus its extension bit
  assign mul_ybits = {mul_y[16], mul_y, 1'b0};
  for (genvar g = 0; g < AIU_BOOTH_DIGITS; g++) begin : g_booth
    assign pp[g] = booth_pp(mul_ybits[2*g+2 -: 3], mul_a, g);
  end

  always_comb begin
    mul_sum = '0;
    for (int i = 0; i < AIU_BOOTH_DIGITS; i++) begin
      mul_sum = mul_sum + pp[i];
    end
  end

  logic take;
  logic sgn;
  logic b_short;
  logic a_neg;
  logic b_neg;
  logic [31:0] a_mag;
  logic [31:0] b_mag;
  logic [5:0] div_bits;
  logic [5:0] div_rep;
  logic [63:0] prod;
  logic prod_done;
  aiu_op_t prod_op;
  logic [63:0] stp;

  always_comb begin
    take = issue_valid_in && ready_ff;
    sgn = issue_in.is_signed;
    // size found from operand_b alone
    if (sgn) begin
      b_short = &issue_in.operand_b[31:15] ||
                ~|issue_in.operand_b[31:15];
    end else begin
      b_short = ~|issue_in.operand_b[31:16];
    end
    a_neg = sgn && issue_in.operand_a[31];
    b_neg = sgn && issue_in.operand_b[31];
    a_mag = a_neg ? (~issue_in.operand_a + 32'h1) : issue_in.operand_a;
    b_mag = b_neg ? (~issue_in.operand_b + 32'h1) : issue_in.operand_b;
    // early-in: how far the dividend's sign extension reaches
    if (sgn ? (&issue_in.operand_a[31:7] || ~|issue_in.operand_a[31:7])
            : ~|issue_in.operand_a[31:8]) begin
      div_bits = 6'(AIU_W - AIU_SKIP_8);
      div_rep = AIU_DIV_REP_8;
    end else if (sgn ? (&issue_in.operand_a[31:15] ||
                        ~|issue_in.operand_a[31:15])
                     : ~|issue_in.operand_a[31:16]) begin
      div_bits = 6'(AIU_W - AIU_SKIP_16);
      div_rep = AIU_DIV_REP_16;
    end else if (sgn ? (&issue_in.operand_a[31:23] ||
                        ~|issue_in.operand_a[31:23])
                     : ~|issue_in.operand_a[31:24]) begin
      div_bits = 6'(AIU_W - AIU_SKIP_24);
      div_rep = AIU_DIV_REP_24;
    end else begin
      div_bits = 6'(AIU_W);
      div_rep = AIU_DIV_REP_32;
    end

    // array input: second pass owns it, otherwise the new issue
    if (state_ff == AIU_PASS2) begin
      mul_a = {p2_sgn_ff && p2_a_ff[31], p2_a_ff};
      mul_y = {p2_sgn_ff && p2_bhi_ff[15], p2_bhi_ff};
    end else begin
      mul_a = {a_neg, issue_in.operand_a};
      mul_y = {b_short && b_neg, issue_in.operand_b[15:0]};
    end
  end

  // kept apart from the decode so the array sum never feeds its own inputs
  always_comb begin
    nxt_state = state_ff;
    nxt_pair = pair_ff;
    nxt_p2_op = p2_op_ff;
    nxt_p2_sgn = p2_sgn_ff;
    nxt_p2_a = p2_a_ff;
    nxt_p2_bhi = p2_bhi_ff;
    nxt_p2_lo = p2_lo_ff;
    nxt_stage = '0;
    nxt_gpr = stage_ff;
    nxt_div_cnt = div_cnt_ff;
    nxt_div_left = div_left_ff;
    nxt_div_rem = div_rem_ff;
    nxt_div_quo = div_quo_ff;
    nxt_div_d = div_d_ff;
    nxt_div_qneg = div_qneg_ff;
    nxt_div_rneg = div_rneg_ff;
    prod = 64'(mul_sum);
    prod_done = 1'b0;
    prod_op = issue_in.op;
    stp = '0;

    case (state_ff)
      AIU_IDLE: begin
        if (take) begin
          case (issue_in.op)
            AIU_PRODUCT_TO_PAIR, AIU_PRODUCT_ACCUMULATE,
            AIU_PRODUCT_DEDUCT, AIU_PRODUCT_TO_REG: begin
              if (b_short) begin
                prod_done = 1'b1;
              end else begin
                // full width: park low pass, high slice next cycle
                nxt_state = AIU_PASS2;
                nxt_p2_op = issue_in.op;
                nxt_p2_sgn = sgn;
                nxt_p2_a = issue_in.operand_a;
                nxt_p2_bhi = issue_in.operand_b[31:16];
                nxt_p2_lo = 64'(mul_sum);
              end
            end
            AIU_QUOTIENT_OP: begin
              // first quotient bit is taken in the issue cycle
              stp = div_step(32'h0, a_mag << (AIU_W - int'(div_bits)),
                             b_mag);
              nxt_div_rem = stp[63:32];
              nxt_div_quo = stp[31:0];
              nxt_div_d = b_mag;
              nxt_div_qneg = a_neg ^ b_neg;
              nxt_div_rneg = a_neg;
              nxt_div_cnt = div_rep - AIU_CNT_LAST;
              nxt_div_left = div_bits - AIU_CNT_LAST;
              nxt_state = AIU_DIVIDE;
            end
            AIU_COPY_UPPER: begin
              nxt_stage = '{vld: 1'b1, data: pair_ff[63:32]};
            end
            AIU_COPY_BOTTOM: begin
              nxt_stage = '{vld: 1'b1, data: pair_ff[31:0]};
            end
            default: begin
            end
          endcase
        end
      end
      AIU_PASS2: begin
        prod = p2_lo_ff + (64'(mul_sum) << AIU_SLICE_W);
        prod_done = 1'b1;
        prod_op = p2_op_ff;
        nxt_state = AIU_IDLE;
      end
      AIU_DIVIDE: begin
        // steps stop once the sized dividend is used up; further shifts
        // would scale it, so the leftover cycles only hold the result
        if (div_left_ff != AIU_CNT_IDLE) begin
          stp = div_step(div_rem_ff, div_quo_ff, div_d_ff);
          nxt_div_rem = stp[63:32];
          nxt_div_quo = stp[31:0];
          nxt_div_left = div_left_ff - AIU_CNT_LAST;
        end else begin
          stp = {div_rem_ff, div_quo_ff};
        end
        nxt_div_cnt = div_cnt_ff - AIU_CNT_LAST;
        if (div_cnt_ff == AIU_CNT_LAST) begin
          nxt_state = AIU_IDLE;
          nxt_div_cnt = AIU_CNT_IDLE;
          nxt_pair[31:0] = div_qneg_ff ? (~stp[31:0] + 32'h1)
                                       : stp[31:0];
          nxt_pair[63:32] = div_rneg_ff ? (~stp[63:32] + 32'h1)
                                        : stp[63:32];
        end
      end
      default: begin
        nxt_state = AIU_IDLE;
      end
    endcase

    if (prod_done) begin
      case (prod_op)
        AIU_PRODUCT_TO_PAIR: nxt_pair = prod;
        AIU_PRODUCT_ACCUMULATE: nxt_pair = pair_ff + prod;
        AIU_PRODUCT_DEDUCT: nxt_pair = pair_ff - prod;
        AIU_PRODUCT_TO_REG: begin
          nxt_stage = '{vld: 1'b1, data: prod[31:0]};
        end
        default: begin
        end
      endcase
    end

    // pair readers and all other ops wait on a pending pair result
    nxt_ready = (nxt_state == AIU_IDLE);
  end

  // no stall input: the unit always advances on its own
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= AIU_IDLE;
      ready_ff <= 1'b0;
      pair_ff <= '0;
      p2_op_ff <= AIU_PRODUCT_TO_PAIR;
      p2_sgn_ff <= 1'b0;
      p2_a_ff <= '0;
      p2_bhi_ff <= '0;
      p2_lo_ff <= '0;
      stage_ff <= '0;
      gpr_ff <= '0;
      div_cnt_ff <= AIU_CNT_IDLE;
      div_left_ff <= AIU_CNT_IDLE;
      div_rem_ff <= '0;
      div_quo_ff <= '0;
      div_d_ff <= '0;
      div_qneg_ff <= 1'b0;
      div_rneg_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      pair_ff <= nxt_pair;
      p2_op_ff <= nxt_p2_op;
      p2_sgn_ff <= nxt_p2_sgn;
      p2_a_ff <= nxt_p2_a;
      p2_bhi_ff <= nxt_p2_bhi;
      p2_lo_ff <= nxt_p2_lo;
      stage_ff <= nxt_stage;
      gpr_ff <= nxt_gpr;
      div_cnt_ff <= nxt_div_cnt;
      div_left_ff <= nxt_div_left;
      div_rem_ff <= nxt_div_rem;
      div_quo_ff <= nxt_div_quo;
      div_d_ff <= nxt_div_d;
      div_qneg_ff <= nxt_div_qneg;
      div_rneg_ff <= nxt_div_rneg;
    end
  end

  assign ready_out = ready_ff;
  assign gpr_out = gpr_ff;
  assign upper_result_out = pair_ff[63:32];
  assign bottom_result_out = pair_ff[31:0];

endmodule

// ---- core/aiu_pkg.sv ----
package aiu_pkg;

  localparam int AIU_W = 32;
  localparam int AIU_SLICE_W = 16;
  localparam int AIU_BOOTH_DIGITS = 9;
  localparam int AIU_PP_W = 51;

  // dividend sizes reached by the early-in check, as skipped iterations
  localparam int AIU_SKIP_8 = 23;
  localparam int AIU_SKIP_16 = 15;
  localparam int AIU_SKIP_24 = 7;

  // divide repeat rates per dividend size; the pair result lands as issue reopens
  localparam logic [5:0] AIU_DIV_REP_8 = 6'h0b;
  localparam logic [5:0] AIU_DIV_REP_16 = 6'h12;
  localparam logic [5:0] AIU_DIV_REP_24 = 6'h19;
  localparam logic [5:0] AIU_DIV_REP_32 = 6'h20;

  localparam logic [5:0] AIU_CNT_LAST = 6'h01;
  localparam logic [5:0] AIU_CNT_IDLE = 6'h00;

  typedef enum logic [2:0] {
    AIU_PRODUCT_TO_PAIR,
    AIU_PRODUCT_ACCUMULATE,
    AIU_PRODUCT_DEDUCT,
    AIU_PRODUCT_TO_REG,
    AIU_QUOTIENT_OP,
    AIU_COPY_UPPER,
    AIU_COPY_BOTTOM
  } aiu_op_t;

  typedef enum logic [1:0] {
    AIU_IDLE,
    AIU_PASS2,
    AIU_DIVIDE
  } aiu_state_t;

  typedef struct packed {
    aiu_op_t op;
    logic is_signed;
    logic [AIU_W-1:0] operand_a;
    logic [AIU_W-1:0] operand_b;
  } aiu_issue_t;

  typedef struct packed {
    logic vld;
    logic [AIU_W-1:0] data;
  } aiu_gpr_t;

endpackage

// ---- test/aiu_chk_asserts.sv ----
`timescale 1ns/1ps
module aiu_chk
  import aiu_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // issue side
  input wire logic issue_valid_in,
  input wire aiu_issue_t issue_in,
  input wire logic ready_out,
  // results
  input wire aiu_gpr_t gpr_out,
  input wire logic [DATA_W-1:0] upper_result_out,
  input wire logic [DATA_W-1:0] bottom_result_out
);
  logic tk, sh, mul, a8, a24;
  logic signed [32:0] xa, xb;
  logic [63:0] pr, pair;
  always_comb begin
    tk = issue_valid_in && ready_out;
    xa = {issue_in.is_signed & issue_in.operand_a[31], issue_in.operand_a};
    xb = {issue_in.is_signed & issue_in.operand_b[31], issue_in.operand_b};
    pr = xa * xb;
    // size found from operand values alone, as the unit must
    sh = issue_in.operand_b[31:16] ==
      {16{issue_in.is_signed & issue_in.operand_b[15]}};
    a8 = issue_in.is_signed ?
      (issue_in.operand_a[31:7] == {25{issue_in.operand_a[7]}}) :
      (issue_in.operand_a[31:8] == 24'h0);
    a24 = issue_in.is_signed ?
      (issue_in.operand_a[31:23] == {9{issue_in.operand_a[23]}}) :
      (issue_in.operand_a[31:24] == 8'h0);
    mul = issue_in.op < AIU_QUOTIENT_OP;
    pair = {upper_result_out, bottom_result_out};
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  full_rate_a: assert property (
    tk && mul && !sh |=> !ready_out ##1 ready_out)
    else $error("full multiply spacing wrong");
  short_rate_a: assert property (
    tk && mul && sh |=> ready_out)
    else $error("short multiply blocked issue");
  pair_short_a: assert property (
    tk && issue_in.op == AIU_PRODUCT_TO_PAIR && sh
    |=> pair == $past(pr))
    else $error("short pair product wrong");
  pair_full_a: assert property (
    tk && issue_in.op == AIU_PRODUCT_TO_PAIR && !sh
    |-> ##2 pair == $past(pr, 2))
    else $error("full pair product wrong");
  reg_short_a: assert property (
    tk && issue_in.op == AIU_PRODUCT_TO_REG && sh
    |-> ##2 gpr_out.vld && gpr_out.data == $past(pr[31:0], 2))
    else $error("register product wrong");
  div_hold_a: assert property (
    tk && issue_in.op == AIU_QUOTIENT_OP
    |=> !ready_out [*8] ##1 !ready_out ##1 !ready_out)
    else $error("issue open during divide");
  div_short_a: assert property (
    tk && issue_in.op == AIU_QUOTIENT_OP && a8
    |-> ##11 ready_out)
    else $error("small divide not done");
  div_long_a: assert property (
    tk && issue_in.op == AIU_QUOTIENT_OP && !a24
    |-> ##31 !ready_out ##1 ready_out)
    else $error("wide divide timing wrong");
  copy_up_a: assert property (
    tk && issue_in.op == AIU_COPY_UPPER
    |-> ##2 gpr_out.vld && gpr_out.data == $past(upper_result_out, 2))
    else $error("upper copy wrong");
  cover property (tk && issue_in.op == AIU_QUOTIENT_OP);
  cover property (tk && mul && !sh);
  cover property (gpr_out.vld);
endmodule

bind arith_iterative_unit aiu_chk #(.DATA_W(DATA_W)) i_aiu_chk (
  .clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in),
  .issue_valid_in(issue_valid_in),
  .issue_in(issue_in),
  .ready_out(ready_out),
  .gpr_out(gpr_out),
  .upper_result_out(upper_result_out),
  .bottom_result_out(bottom_result_out)
);

// ---- test/aiu_pipe_model.sv ----
`timescale 1ns/1ps
module aiu_pipe_model
  import aiu_pkg::*;
(
  // clock and unit handshake
  input wire logic clk_sys_in,
  input wire logic ready_in,
  // issue towards the unit
  output logic valid_out,
  output aiu_issue_t issue_out
);
  initial begin
    valid_out = 1'b0;
    issue_out = '0;
  end
  // call at a falling edge; returns one falling edge after the take,
  // still offering, so the caller may chain a send or call idle
  task automatic send(input aiu_op_t op, input logic sg,
    input logic [31:0] a, input logic [31:0] b, output int st);
    st = 0;
    valid_out = 1'b1;
    issue_out = '{op, sg, a, b};
    while (ready_in !== 1'b1) begin
      @(negedge clk_sys_in);
      st++;
    end
    @(negedge clk_sys_in);
  endtask
  // stale operands are scrambled so nothing leans on them
  task automatic idle();
    valid_out = 1'b0;
    issue_out = aiu_issue_t'(~issue_out);
  endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import aiu_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic issue_valid_in;
  logic ready_out;
  aiu_issue_t issue_in;
  aiu_gpr_t gpr_out;
  logic [31:0] upper_result_out;
  logic [31:0] bottom_result_out;
  logic [31:0] gdat;
  logic [63:0] pe;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int gcyc = 0;

  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (gpr_out.vld === 1'b1) begin
      gcyc <= cyc;
      gdat <= gpr_out.data;
    end
  end

  arith_iterative_unit i_arith_iterative_unit (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .issue_valid_in(issue_valid_in),
    .issue_in(issue_in),
    .ready_out(ready_out),
    .gpr_out(gpr_out),
    .upper_result_out(upper_result_out),
    .bottom_result_out(bottom_result_out)
  );
  aiu_pipe_model i_aiu_pipe_model (
    .clk_sys_in(clk_sys_in),
    .ready_in(ready_out),
    .valid_out(issue_valid_in),
    .issue_out(issue_in)
  );

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [63:0] prod(input logic sg,
    input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] x, y;
    x = {sg & a[31], a};
    y = {sg & b[31], b};
    return x * y;
  endfunction

  task automatic t_mul();
    int st;
    i_aiu_pipe_model.send(AIU_PRODUCT_TO_PAIR, 1'b1, 32'hfffff001,
      32'hffff8000, st);
    cmp(st, 0);
    i_aiu_pipe_model.send(AIU_PRODUCT_ACCUMULATE, 1'b0, 32'hffffffff,
      32'h0000ffff, st);
    cmp(st, 0);
    i_aiu_pipe_model.send(AIU_PRODUCT_DEDUCT, 1'b1, 32'h12345678,
      32'h00018000, st);
    cmp(st, 0);
    i_aiu_pipe_model.send(AIU_PRODUCT_ACCUMULATE, 1'b1, 32'h7fffffff,
      32'h80000000, st);
    cmp(st, 1);
    i_aiu_pipe_model.idle();
    pe = prod(1'b1, 32'hfffff001, 32'hffff8000);
    pe = pe + prod(1'b0, 32'hffffffff, 32'h0000ffff);
    pe = pe - prod(1'b1, 32'h12345678, 32'h00018000);
    pe = pe + prod(1'b1, 32'h7fffffff, 32'h80000000);
    repeat (3) @(negedge clk_sys_in);
    cmp({upper_result_out, bottom_result_out}, pe);
  endtask

  task automatic t_reg(input logic sg, input logic [31:0] a,
    input logic [31:0] b, input int lat);
    int st, t0;
    i_aiu_pipe_model.send(AIU_PRODUCT_TO_REG, sg, a, b, st);
    t0 = cyc;
    i_aiu_pipe_model.idle();
    repeat (4) @(negedge clk_sys_in);
    cmp(gcyc - t0 + 1, lat);
    cmp(gdat, 32'(prod(sg, a, b)));
    cmp({upper_result_out, bottom_result_out}, pe);
  endtask

  task automatic t_div();
    logic [31:0] dv [5] = '{32'hffffff85, 32'h00007abc, 32'hff812345,
      32'h40000001, 32'hffffff85};
    logic [5:0] rp [5] = '{AIU_DIV_REP_8, AIU_DIV_REP_16, AIU_DIV_REP_24,
      AIU_DIV_REP_32, AIU_DIV_REP_32};
    logic [31:0] q, r, d;
    int st;
    for (int i = 0; i < 5; i++) begin
      if (i < 4) begin
        d = 32'hfffffff9;
        q = $signed(dv[i]) / $signed(d);
        r = $signed(dv[i]) % $signed(d);
      end else begin
        d = 32'h00000007;
        q = dv[i] / d;
        r = dv[i] % d;
      end
      i_aiu_pipe_model.send(AIU_QUOTIENT_OP, i < 4, dv[i], d, st);
      i_aiu_pipe_model.send(AIU_COPY_BOTTOM, 1'b0, d, d, st);
      cmp(st, rp[i] - 1);
      i_aiu_pipe_model.send(AIU_COPY_UPPER, 1'b0, d, d, st);
      i_aiu_pipe_model.idle();
      cmp({upper_result_out, bottom_result_out}, {r, q});
      @(negedge clk_sys_in);
      cmp(gdat, q);
      @(negedge clk_sys_in);
      cmp(gdat, r);
    end
  endtask

  initial begin
    repeat (8) @(negedge clk_sys_in);
    cmp(64'({ready_out, gpr_out}), 64'h0);
    cmp({upper_result_out, bottom_result_out}, 64'h0);
    reset_n_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    t_mul();
    // a signed operand_b of 0x8000 does not fit, so it takes two passes
    t_reg(1'b1, 32'h00000123, 32'h00008000, 3);
    t_reg(1'b0, 32'hfedcba98, 32'h0000ffff, 2);
    t_div();
    tally_and_finish();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    err_count++;
    tally_and_finish();
  end
endmodule
